// [src/scd_clock_ctrl.sv]
// Purpose: System clock select, divide, domain gating, PLL reference and
//          postscaler for a small microcontroller.
// Assumes: Oscillator and PLL levels arrive synchronous to i_clk.
// Notes:   Derived clocks are registered levels of the sampled sources.
//
// How it works
// - Four fuse bits choose crystal, low frequency crystal, RC or external.
// - PLL wants 8 MHz; prescaler passes 8 MHz or halves 16 MHz.
// - PLL reference is the prescaled source or the internal RC oscillator.
// - Enabled PLL output frequency, 32 to 96 MHz, set by PLL register.
// - Postscalers make USB and timer clocks, each divided by 1, 1.5, 2.
// - USB clock is the PLL output halved or passed straight through; the code also offers divide by 1.5.
// - Sleep modes stop unused clocks; stopping CPU clock halts the core.
// - I/O clock feeds peripherals; async interrupts still wake while stopped.
// - Two-wire address matching clock runs in every sleep mode.
// - Flash clock is gated together with the CPU clock.
// - Converter clock runs while CPU and I/O clocks are stopped.
// - Crystal variant ships with crystal source and divide-by-eight on.
// - RC variant ships with internal RC source and divide-by-eight on.
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "scd_defines.svh"
module scd_clock_ctrl #(
   parameter bit RC_VARIANT = 1'b0
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // Fuses
   input  wire logic [3:0]  i_clock_source_select_fuses,
   input  wire logic        i_divide_by_eight_fuse,
   // Sources, PLL and wake-up
   input  wire logic        i_osc_lp_xtal,
   input  wire logic        i_osc_lf_xtal,
   input  wire logic        i_osc_rc,
   input  wire logic        i_osc_ext,
   input  wire logic        i_pll_clk,
   input  wire logic        i_pll_lock,
   input  wire logic        i_wake_async,
   // Domain clocks
   output logic             o_clk_cpu,
   output logic             o_clk_io,
   output logic             o_clk_flash,
   output logic             o_clk_adc,
   output logic             o_clk_twi,
   // PLL side
   output logic             o_pll_ref,
   output logic             o_pll_en,
   output logic      [3:0]  o_pll_freq,
   output logic             o_clk_usb,
   output logic             o_clk_tmr
);
   import scd_pkg::*;
   function automatic scd_src_t decode_src(input logic [3:0] code);
      if (code >= `SCD_CODE_LP_MIN) decode_src = SCD_SRC_LP_XTAL;
      else if (code == `SCD_CODE_LF_HI || code == `SCD_CODE_LF_LO)
         decode_src = SCD_SRC_LF_XTAL;
      else if (code == `SCD_CODE_RC) decode_src = SCD_SRC_RC;
      else if (code == `SCD_CODE_EXT) decode_src = SCD_SRC_EXT;
      else decode_src = SCD_SRC_RSVD;
   endfunction
   function automatic logic [1:0] ps_last(input logic [1:0] ratio);
      case (ratio)
         `SCD_RATIO_1:   ps_last = 2'h1;
         `SCD_RATIO_1P5: ps_last = 2'h2;
         default:        ps_last = 2'h3;
      endcase
   endfunction
   function automatic logic ps_level(input logic [1:0] cnt,
                                     input logic [1:0] ratio,
                                     input logic       lvl);
      ps_level = (ratio == `SCD_RATIO_1) ? lvl : (cnt < 2'h2);
   endfunction
   ///////////////////////////////////////////////////////////////////////////
   logic [3:0]   fuse_code;
   logic         fuse_div8_n, fuse_ok, asleep, ph_wr, ap_valid;
   logic         src_lvl, src_q, src_rise, div8_clk, next_sys;
   logic         pres_tog, pres_lvl, pll_q, pll_edge;
   logic [1:0]   div8_cnt, mode_field;
   logic [1:0]   usb_cnt, usb_ratio, tmr_cnt, tmr_ratio;
   scd_src_t     src;
   scd_sleep_t   eff_mode;
   scd_gate_t    want, gate;
   scd_pll_cfg_t cfg;
   logic [7:0]   ph_addr;
   logic [31:0]  next_rdata;

   // Shipped fuse values stand until the pins are captured after release
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fuse_code   <= RC_VARIANT ? `SCD_SHIP_RC_CODE
                                   : `SCD_SHIP_XTAL_CODE;
         fuse_div8_n <= `SCD_SHIP_DIV8;
         fuse_ok     <= 1'b0;
      end else if (!fuse_ok) begin
         fuse_code   <= i_clock_source_select_fuses;
         fuse_div8_n <= i_divide_by_eight_fuse;
         fuse_ok     <= 1'b1;
      end
   end

   // Reserved codes fall back to the RC oscillator so the core keeps running
   always_comb begin
      src = decode_src(fuse_code);
      case (src)
         SCD_SRC_LP_XTAL: src_lvl = i_osc_lp_xtal;
         SCD_SRC_LF_XTAL: src_lvl = i_osc_lf_xtal;
         SCD_SRC_EXT:     src_lvl = i_osc_ext;
         default:         src_lvl = i_osc_rc;
      endcase
   end

   assign src_rise = src_lvl & ~src_q;
   assign next_sys = fuse_div8_n ? src_lvl : div8_clk;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         src_q    <= 1'b0;
         div8_cnt <= 2'h0;
         div8_clk <= 1'b0;
      end else begin
         src_q <= src_lvl;
         if (src_rise) begin
            div8_cnt <= div8_cnt + 2'h1;
            if (div8_cnt == `SCD_DIV8_LAST)
               div8_clk <= ~div8_clk;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Sleep control; wake-up is sampled on i_clk, which never stops
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         asleep <= 1'b0;
      end else if (i_wake_async) begin
         asleep <= 1'b0;
      end else if (ph_wr && ph_addr == `SCD_CTRL_OFS) begin
         asleep <= i_hwdata[`SCD_CTRL_SLEEP_BIT];
      end
   end

   always_comb begin
      eff_mode = asleep ? scd_sleep_t'(mode_field) : SCD_SLP_RUN;
      case (eff_mode)
         // Field order is cpu, io, flash, adc
         SCD_SLP_IDLE:   want = '{1'b0, 1'b1, 1'b0, 1'b1};
         SCD_SLP_ADC_NR: want = '{1'b0, 1'b0, 1'b0, 1'b1};
         SCD_SLP_PDOWN:  want = '{1'b0, 1'b0, 1'b0, 1'b0};
         default:        want = '{1'b1, 1'b1, 1'b1, 1'b1};
      endcase
   end

   // Gates move only while the system clock is low, so no pulse is cut
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         gate <= '{cpu: 1'b1, io: 1'b1, flash: 1'b1, adc: 1'b1};
      end else if (!next_sys) begin
         gate <= want;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_clk_cpu   <= 1'b0;
         o_clk_io    <= 1'b0;
         o_clk_flash <= 1'b0;
         o_clk_adc   <= 1'b0;
         o_clk_twi   <= 1'b0;
      end else begin
         o_clk_cpu   <= next_sys & gate.cpu;
         o_clk_io    <= next_sys & gate.io;
         o_clk_flash <= next_sys & gate.flash;
         o_clk_adc   <= next_sys & gate.adc;
         o_clk_twi   <= next_sys;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // PLL reference: prescaler ahead of the divide-by-eight stage
   assign pres_lvl = cfg.presc_div2 ? pres_tog : src_lvl;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pres_tog   <= 1'b0;
         o_pll_ref  <= 1'b0;
         o_pll_en   <= 1'b0;
         o_pll_freq <= 4'h0;
      end else begin
         if (src_rise)
            pres_tog <= ~pres_tog;
         o_pll_ref  <= cfg.in_rc ? i_osc_rc : pres_lvl;
         o_pll_en   <= cfg.en;
         o_pll_freq <= cfg.freq;
      end
   end

   // Postscalers count both PLL edges; a new ratio loads at the wrap only
   assign pll_edge = i_pll_clk ^ pll_q;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pll_q     <= 1'b0;
         usb_cnt   <= 2'h0;
         usb_ratio <= `SCD_RATIO_1;
         o_clk_usb <= 1'b0;
      end else begin
         pll_q <= i_pll_clk;
         if (pll_edge) begin
            if (usb_cnt == ps_last(usb_ratio)) begin
               usb_cnt   <= 2'h0;
               usb_ratio <= cfg.usb_ratio;
            end else begin
               usb_cnt <= usb_cnt + 2'h1;
            end
         end
         o_clk_usb <= cfg.en & ps_level(usb_cnt, usb_ratio, i_pll_clk);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tmr_cnt   <= 2'h0;
         tmr_ratio <= `SCD_RATIO_1;
         o_clk_tmr <= 1'b0;
      end else begin
         if (pll_edge) begin
            if (tmr_cnt == ps_last(tmr_ratio)) begin
               tmr_cnt   <= 2'h0;
               tmr_ratio <= cfg.tmr_ratio;
            end else begin
               tmr_cnt <= tmr_cnt + 2'h1;
            end
         end
         o_clk_tmr <= cfg.en & ps_level(tmr_cnt, tmr_ratio, i_pll_clk);
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, every response OKAY
   assign ap_valid = i_hsel & i_htrans[1] & i_hready;
   always_comb begin
      next_rdata = 32'h0;
      case (i_haddr[7:0])
         `SCD_CTRL_OFS:   next_rdata[2:0] = {asleep, mode_field};
         `SCD_PLLCFG_OFS: next_rdata[`SCD_PLLCFG_MSB:0] = cfg;
         `SCD_STATUS_OFS: next_rdata[9:0] = {i_pll_lock, fuse_ok, src,
                                             ~fuse_div8_n, fuse_code};
         default:         next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ph_wr       <= 1'b0;
         ph_addr     <= 8'h0;
         o_hrdata    <= 32'h0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         ph_wr       <= ap_valid & i_hwrite;
         ph_addr     <= i_haddr[7:0];
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         if (ap_valid && !i_hwrite)
            o_hrdata <= next_rdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_field <= `SCD_CTRL_RESET;
         cfg        <= `SCD_PLLCFG_RESET;
      end else if (ph_wr) begin
         if (ph_addr == `SCD_CTRL_OFS)
            mode_field <= i_hwdata[`SCD_CTRL_MODE_MSB:`SCD_CTRL_MODE_LSB];
         if (ph_addr == `SCD_PLLCFG_OFS)
            cfg <= i_hwdata[`SCD_PLLCFG_MSB:0];
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_wake;
      asleep ##0 i_wake_async;
   endsequence
   sequence s_gate_move;
      $changed(gate);
   endsequence
   rc_decode_a: assert property (
      fuse_ok && fuse_code == `SCD_CODE_RC |-> src == SCD_SRC_RC)
      else $error("RC code did not select RC oscillator");
   presc_pass_a: assert property (
      !cfg.presc_div2 && !cfg.in_rc |=> o_pll_ref == $past(src_lvl))
      else $error("Undivided prescaler did not pass source");
   pll_mux_a: assert property (
      cfg.in_rc |=> o_pll_ref == $past(i_osc_rc))
      else $error("PLL reference not taken from RC oscillator");
   pll_freq_a: assert property (
      ##1 o_pll_freq == $past(cfg.freq) && o_pll_en == $past(cfg.en))
      else $error("PLL setting not driven out");
   tmr_ratio_a: assert property (
      cfg.en && tmr_ratio == `SCD_RATIO_1P5 && tmr_cnt == 2'h2 |=> !o_clk_tmr)
      else $error("Timer clock high in low third of 1.5 ratio");
   usb_pass_a: assert property (
      cfg.en && usb_ratio == `SCD_RATIO_1 |=> o_clk_usb == $past(i_pll_clk))
      else $error("USB clock did not follow PLL");
   cpu_stop_a: assert property (
      !gate.cpu |=> !o_clk_cpu)
      else $error("CPU clock ran while gated");
   wake_a: assert property (
      s_wake |=> !asleep ##1 gate.cpu || $past(next_sys))
      else $error("Wake-up did not end sleep");
   twi_run_a: assert property (
      ##1 o_clk_twi == $past(next_sys))
      else $error("Two-wire clock was gated");
   flash_cpu_a: assert property (
      gate.flash == gate.cpu)
      else $error("Flash clock gate differs from CPU gate");
   adc_keep_a: assert property (
      eff_mode == SCD_SLP_ADC_NR && !next_sys |=> gate.adc && !gate.io)
      else $error("Converter clock not kept in noise reduction");
   glitch_free_a: assert property (
      s_gate_move |-> !o_clk_cpu && !o_clk_io && !o_clk_adc)
      else $error("Gate moved while clock was high");

endmodule

// [src/scd_defines.svh]
// Purpose: Offsets, field positions, reset values and counts of the clock
//          control block.
// Assumes: Included by its bare name.
// Notes:   Fuse bits read 0 when programmed.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// Register byte offsets
`define SCD_CTRL_OFS       8'h00
`define SCD_PLLCFG_OFS     8'h04
`define SCD_STATUS_OFS     8'h08

// Control register fields
`define SCD_CTRL_MODE_LSB  0
`define SCD_CTRL_MODE_MSB  1
`define SCD_CTRL_SLEEP_BIT 2
`define SCD_CTRL_RESET     2'h0

// PLL configuration field, low bits of its word
`define SCD_PLLCFG_MSB     10
`define SCD_PLLCFG_RESET   11'h000

// Clock source fuse codes
`define SCD_CODE_LP_MIN    4'h8
`define SCD_CODE_LF_HI     4'h5
`define SCD_CODE_LF_LO     4'h4
`define SCD_CODE_RC        4'h2
`define SCD_CODE_EXT       4'h0

// Shipped fuse values: crystal and internal oscillator variants
`define SCD_SHIP_XTAL_CODE 4'hf
`define SCD_SHIP_RC_CODE   4'h2
`define SCD_SHIP_DIV8      1'b0

// Postscaler ratio codes
`define SCD_RATIO_1        2'h0
`define SCD_RATIO_1P5      2'h1
`define SCD_RATIO_2        2'h2

// Source edges per half period of the divide-by-eight clock, minus one
`define SCD_DIV8_LAST      2'h3

`endif

// [src/scd_pkg.sv]
// Purpose: Types shared by the clock control block.
// Assumes: Nothing.
// Notes:   Constants live in scd_defines.svh.
package scd_pkg;

   typedef enum logic [2:0] {
      SCD_SRC_LP_XTAL,
      SCD_SRC_LF_XTAL,
      SCD_SRC_RC,
      SCD_SRC_EXT,
      SCD_SRC_RSVD
   } scd_src_t;

   typedef enum logic [1:0] {
      SCD_SLP_RUN,
      SCD_SLP_IDLE,
      SCD_SLP_ADC_NR,
      SCD_SLP_PDOWN
   } scd_sleep_t;

   typedef struct packed {
      logic [1:0] tmr_ratio;
      logic [1:0] usb_ratio;
      logic [3:0] freq;
      logic       presc_div2;
      logic       in_rc;
      logic       en;
   } scd_pll_cfg_t;

   typedef struct packed {
      logic cpu;
      logic io;
      logic flash;
      logic adc;
   } scd_gate_t;

endpackage

// [sim/test_system_clock_select_and_distribution.sv]
// Purpose: Self-checking bench for the clock control block.
// Assumes: Bench acts as fuses, oscillators, PLL and bus master.
// Notes:   Clock outputs are judged by rising-edge counts in a window.
`timescale 1ns/10ps
`include "scd_defines.svh"

module test_system_clock_select_and_distribution;
   import scd_pkg::*;
   typedef struct {logic [31:0] v; int t;} scd_exp_t;
   logic        i_clk = 0, i_reset_n = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, o_hrdata, res_val;
   logic [1:0]  htrans = 0;
   logic [3:0]  fuse = 4'hf, cyc = 4'h0;
   logic        div8 = 0, lp = 0, lf = 0, rc = 0, ext = 0, pll = 0;
   logic        lock = 0, wake = 0;
   logic        o_hreadyout, o_hresp, o_pll_en;
   logic [3:0]  o_pll_freq;
   logic [7:0]  clks;
   int          fail_count = 0, check_count = 0, cnt [8];
   scd_exp_t    exp_q [$];
   scd_pll_cfg_t cfg;
   event        res_ev;

   always #50 i_clk = ~i_clk;

   // Oscillators differ in rate so the chosen source is visible
   always @(posedge i_clk) begin
      cyc <= cyc + 4'h1;
      rc  <= ~rc;
      lp  <= cyc[1];
      ext <= cyc[2];
      lf  <= cyc[3];
      pll <= ~pll;
   end

   scd_clock_ctrl #(.RC_VARIANT(1'b0)) dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(o_hreadyout),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_clock_source_select_fuses(fuse), .i_divide_by_eight_fuse(div8),
      .i_osc_lp_xtal(lp), .i_osc_lf_xtal(lf), .i_osc_rc(rc),
      .i_osc_ext(ext), .i_pll_clk(pll), .i_pll_lock(lock),
      .i_wake_async(wake), .o_clk_cpu(clks[0]), .o_clk_io(clks[1]),
      .o_clk_flash(clks[2]), .o_clk_adc(clks[3]), .o_clk_twi(clks[4]),
      .o_pll_ref(clks[5]), .o_pll_en(o_pll_en), .o_pll_freq(o_pll_freq),
      .o_clk_usb(clks[6]), .o_clk_tmr(clks[7]));

   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] ex,
                        input int tol);
      check_count++;
      if (tol == 0 ? seen !== ex
          : (^seen === 1'bx || seen > ex + tol || seen + tol < ex)) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, ex);
      end
   endtask

   task automatic note(input logic [31:0] v, input int t);
      exp_q.push_back('{v, t});
   endtask

   task automatic report(input logic [31:0] v);
      res_val = v;
      ->res_ev;
      #1;
   endtask

   // Results are paired with the oldest note
   initial forever begin
      scd_exp_t e;
      @(res_ev);
      e = exp_q.pop_front();
      check(res_val, e.v, e.t);
   end

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge i_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_clk); while (o_hreadyout !== 1'b1);
      rd = o_hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
      logic [31:0] x;
      note(ex, 0);
      ahb(1'b0, a, 32'h0, x);
      report(x);
   endtask

   // Counts rising edges of every derived clock over 96 cycles
   task automatic window();
      logic [7:0] p, c;
      repeat (16) @(posedge i_clk);
      foreach (cnt[i]) cnt[i] = 0;
      p = clks;
      repeat (96) begin
         @(posedge i_clk);
         c = clks;
         foreach (cnt[i]) cnt[i] += int'(p[i] === 1'b0 && c[i] === 1'b1);
         p = c;
      end
   endtask

   task automatic cnt_chk(input int i, input int ex);
      note(ex, 1);
      report(cnt[i]);
   endtask

   task automatic do_reset(input logic [3:0] c, input logic d, input int n);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      fuse      <= c;
      div8      <= d;
      repeat (n) @(posedge i_clk);
      note(32'h10, 0);
      report({o_hreadyout, clks[4], clks[0], clks[6], o_hresp});
      i_reset_n <= 1'b1;
   endtask

   function automatic logic [2:0] src_of(input logic [3:0] c);
      if (c[3]) return 3'h0;
      if (c == `SCD_CODE_LF_HI || c == `SCD_CODE_LF_LO) return 3'h1;
      if (c == `SCD_CODE_RC) return 3'h2;
      if (c == `SCD_CODE_EXT) return 3'h3;
      return 3'h4;
   endfunction

   function automatic int rate(input logic [2:0] s);
      return s == 3'h0 ? 24 : s == 3'h1 ? 6 : s == 3'h3 ? 12 : 48;
   endfunction

   function automatic int post(input logic [1:0] r);
      return r == `SCD_RATIO_1 ? 48 : r == `SCD_RATIO_1P5 ? 32 : 24;
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #2000000;
      fail_count++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      logic d;
      logic [2:0] s;
      void'($urandom(32'hb46614fe));
      do_reset(4'hf, 1'b0, 16);
      // Every fuse code; shipped codes keep divide-by-eight programmed
      for (int c = 0; c < 16; c++) begin
         d = (c == 15 || c == 2) ? `SCD_SHIP_DIV8 : 1'($urandom);
         lock <= 1'($urandom);
         do_reset(4'(c), d, 4);
         s = src_of(4'(c));
         rd_chk(`SCD_STATUS_OFS, {22'h0, lock, 1'b1, s, ~d, 4'(c)});
         window();
         cnt_chk(4, d ? rate(s) : rate(s) / 8);
      end
      rd_chk(8'h0c, 32'h0);
      wr(8'h0c, 32'hffffffff);
      rd_chk(8'h0c, 32'h0);
      // Sleep modes on the RC source, wake by the async request
      do_reset(`SCD_CODE_RC, 1'b1, 4);
      for (int m = 0; m < 4; m++) begin
         wr(`SCD_CTRL_OFS, {29'h0, 1'b1, 2'(m)});
         rd_chk(`SCD_CTRL_OFS, {29'h0, 1'b1, 2'(m)});
         window();
         cnt_chk(0, m == 0 ? 48 : 0);
         cnt_chk(2, m == 0 ? 48 : 0);
         cnt_chk(1, m < 2 ? 48 : 0);
         cnt_chk(3, m < 3 ? 48 : 0);
         cnt_chk(4, 48);
         @(posedge i_clk);
         wake <= 1'b1;
         @(posedge i_clk);
         wake <= 1'b0;
         rd_chk(`SCD_CTRL_OFS, {30'h0, 2'(m)});
         window();
         cnt_chk(0, 48);
         cnt_chk(1, 48);
      end
      // PLL reference path, frequency setting and postscalers
      do_reset(`SCD_CODE_EXT, 1'b1, 4);
      for (int k = 0; k < 5; k++) begin
         cfg.en         = k < 4;
         cfg.in_rc      = k[1];
         cfg.presc_div2 = k[0];
         cfg.freq       = 4'($urandom);
         cfg.usb_ratio  = 2'(k);
         cfg.tmr_ratio  = 2'(k + 1);
         wr(`SCD_PLLCFG_OFS, {21'($urandom), cfg});
         rd_chk(`SCD_PLLCFG_OFS, {21'h0, cfg});
         note({27'h0, cfg.en, cfg.freq}, 0);
         report({o_pll_en, o_pll_freq});
         window();
         cnt_chk(5, cfg.in_rc ? 48 : cfg.presc_div2 ? 6 : 12);
         cnt_chk(6, cfg.en ? post(cfg.usb_ratio) : 0);
         cnt_chk(7, cfg.en ? post(cfg.tmr_ratio) : 0);
      end
      give_verdict();
   end
endmodule
